// [flag_status_pkg.sv]
// Purpose: Constants for the generic flag status word returned to the host.
// Assumes: A frame decoder elsewhere presents each received 32-bit command word as a one-cycle strobe.
// Notes: The flag register has no bus offset; it is reached by its message selector.
package flag_status_pkg;
   localparam int cmd_width = 32;
   localparam int rw_bit = 31;
   localparam int sel_msb = 30;
   localparam int sel_lsb = 27;
   localparam logic [3:0] sel_generic_flags = 4'hf;
   localparam logic rw_read = 1'b0;
   localparam int overvoltage_bit = 3;
   localparam int phase_sync_bit = 2;
   localparam int enable_latch_bit = 1;
   localparam int reset_latch_bit = 0;
   localparam logic overvoltage_reset = 1'b0;
   localparam logic phase_sync_reset = 1'b0;
   localparam logic enable_latch_reset = 1'b1;
   localparam logic reset_latch_reset = 1'b1;
endpackage : flag_status_pkg

// [edge_fall_detect.sv]
// Purpose: Flags a high-to-low change of a synchronous level.
// Assumes: Input is already synchronous to ref_clk.
// Notes: The history starts high so a level already low at release of reset reads as a fall.
`timescale 1ns/1ns
module edge_fall_detect (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Level in, pulse out
   input wire logic level,
   output logic fell
);
   typedef struct packed {
      logic last;
   } edge_state_type;
   edge_state_type state;
   edge_state_type next_state;
   always_comb begin
      next_state = state;
      next_state.last = level;
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{last: 1'b1};
      end else begin
         state <= next_state;
      end
   end
   assign fell = state.last & ~level;
endmodule : edge_fall_detect

// [generic_flag_status_read.sv]
// Purpose: Sticky device flags returned on a generic flag read command.
// Assumes: cmd_valid is a one-cycle strobe with cmd_word stable in that cycle.
// Notes: Response appears one cycle after the command; read side effects land in the same edge.
`timescale 1ns/1ns
module generic_flag_status_read
   import flag_status_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Command word from the serial frame decoder
   input wire logic cmd_valid,
   input wire logic [31:0] cmd_word,
   // Device event sources
   input wire logic overvoltage_event,
   input wire logic phase_sync_event,
   input wire logic enable_in,
   input wire logic reset_in_n,
   // Response toward the serial shifter
   output logic resp_valid,
   output logic [31:0] resp_word,
   // Live flag view
   output logic [3:0] flags
);
   typedef struct packed {
      logic overvoltage_flag;
      logic phase_sync_flag;
      logic enable_latch;
      logic reset_event_latch;
      logic resp_valid;
      logic [31:0] resp_word;
   } flag_state_type;

   flag_state_type state;
   flag_state_type next_state;
   logic reset_fell;
   logic flag_read;

   // Writes and every other selector fall through here untouched.
   // They must not clear anything, since other blocks own those messages.
   function automatic logic is_flag_read(input logic [31:0] w);
      is_flag_read = (w[rw_bit] == rw_read) && (w[sel_msb:sel_lsb] == sel_generic_flags);
   endfunction : is_flag_read

   edge_fall_detect reset_edge (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .level(reset_in_n),
      .fell(reset_fell)
   );

   assign flag_read = cmd_valid && is_flag_read(cmd_word);

   // Clears from a read are applied first and sets from events last.
   // This way an event in the read cycle is never lost; it shows in the next read.
   // A low enable input likewise wins over the read clear of the enable latch.
   always_comb begin
      next_state = state;
      next_state.resp_valid = flag_read;
      if (flag_read) begin
         // The word returned is the flags as they stood before this read clears them.
         next_state.resp_word = '0;
         next_state.resp_word[rw_bit] = 1'b0;
         next_state.resp_word[sel_msb:sel_lsb] = sel_generic_flags;
         next_state.resp_word[overvoltage_bit] = state.overvoltage_flag;
         next_state.resp_word[phase_sync_bit] = state.phase_sync_flag;
         next_state.resp_word[enable_latch_bit] = state.enable_latch;
         next_state.resp_word[reset_latch_bit] = state.reset_event_latch;
         next_state.overvoltage_flag = 1'b0;
         next_state.phase_sync_flag = 1'b0;
         next_state.reset_event_latch = 1'b0;
         if (enable_in) begin
            next_state.enable_latch = 1'b0;
         end
      end
      // Events are applied after the clear so one landing on a read edge is kept.
      if (overvoltage_event) begin
         next_state.overvoltage_flag = 1'b1;
      end
      if (phase_sync_event) begin
         next_state.phase_sync_flag = 1'b1;
      end
      if (!enable_in) begin
         next_state.enable_latch = 1'b1;
      end
      if (reset_fell) begin
         next_state.reset_event_latch = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '{overvoltage_flag: overvoltage_reset, phase_sync_flag: phase_sync_reset,
                    enable_latch: enable_latch_reset, reset_event_latch: reset_latch_reset,
                    resp_valid: 1'b0, resp_word: 32'h0000_0000};
      end else begin
         state <= next_state;
      end
   end

   assign resp_valid = state.resp_valid;
   assign resp_word = state.resp_word;
   assign flags = {state.overvoltage_flag, state.phase_sync_flag, state.enable_latch, state.reset_event_latch};

   // The checks below are idle while reset is held, so the reset values never trip them.
   // Each one looks one edge ahead at most, which keeps them cheap to evaluate.

   // Only a read of the generic selector may produce a response, and it always does.
   a_decode_response: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      resp_valid |-> $past(cmd_valid)
      && $past(cmd_word[sel_msb:sel_lsb]) == sel_generic_flags && $past(cmd_word[rw_bit]) == rw_read)
      else $error("Response without a generic flag read");

   a_read_answered: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read
      |=> resp_valid)
      else $error("Flag read not answered");

   a_refused_silent: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      cmd_valid && !flag_read
      |=> !resp_valid)
      else $error("Refused command answered");

   // The overvoltage flag is sticky until a read that has no new event with it.
   a_overvoltage_sticky: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      overvoltage_event
      |=> flags[overvoltage_bit])
      else $error("Overvoltage event lost");

   a_overvoltage_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flags[overvoltage_bit] && !flag_read
      |=> flags[overvoltage_bit])
      else $error("Overvoltage flag dropped without read");

   a_overvoltage_clear: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read && !overvoltage_event
      |=> !flags[overvoltage_bit])
      else $error("Overvoltage flag not cleared by read");

   // The phase sync flag follows the same sticky pattern.
   a_sync_sticky: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      phase_sync_event
      |=> flags[phase_sync_bit])
      else $error("Phase sync event lost");

   a_sync_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flags[phase_sync_bit] && !flag_read
      |=> flags[phase_sync_bit])
      else $error("Phase sync flag not held");

   a_sync_clear: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read && !phase_sync_event
      |=> !flags[phase_sync_bit])
      else $error("Phase sync flag not cleared by read");

   // The enable latch only falls on a read with the enable input high.
   a_en_clear: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read && enable_in
      |=> !flags[enable_latch_bit])
      else $error("Enable latch not cleared by read");

   a_en_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flags[enable_latch_bit] && !flag_read
      |=> flags[enable_latch_bit])
      else $error("Enable latch dropped without read");

   a_en_stay_low: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !flags[enable_latch_bit] && enable_in
      |=> !flags[enable_latch_bit])
      else $error("Enable latch rose with enable high");

   a_en_force: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !enable_in
      |=> flags[enable_latch_bit])
      else $error("Enable latch not forced while enable low");

   a_en_read_low: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read && !enable_in
      |=> flags[enable_latch_bit])
      else $error("Read cleared enable latch while enable low");

   // The reset latch falls on every read that has no falling reset input with it, and rises only on a falling reset input.
   a_reset_latch_clear: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flag_read && !reset_fell
      |=> !flags[reset_latch_bit])
      else $error("Reset latch not cleared by read");

   a_reset_latch_hold: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      flags[reset_latch_bit] && !flag_read
      |=> flags[reset_latch_bit])
      else $error("Reset latch dropped without read");

   a_reset_latch_set: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      $fell(reset_in_n)
      |=> flags[reset_latch_bit])
      else $error("Reset falling edge not latched");

   a_reset_latch_quiet: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !flags[reset_latch_bit] && !$fell(reset_in_n)
      |=> !flags[reset_latch_bit])
      else $error("Reset latch set without falling edge");

   // The response carries the flags as they stood before the read, and then stands still.
   a_resp_format: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      resp_valid |-> resp_word[rw_bit] == 1'b0 && resp_word[sel_msb:sel_lsb] == sel_generic_flags
      && resp_word[sel_lsb-1:overvoltage_bit+1] == '0 && resp_word[overvoltage_bit:reset_latch_bit] == $past(flags))
      else $error("Response word malformed");

   a_resp_stands: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      !flag_read
      |=> $stable(resp_word))
      else $error("Response word changed without read");
endmodule : generic_flag_status_read

// [host_model.sv]
// Purpose: Host side that issues command words to the flag block.
// Assumes: One command word per strobe cycle.
// Notes: A released word shows its inverse so stale data is never seen.
`timescale 1ns/1ns
module host_model (
   // Clock
   input wire logic ref_clk,
   // Command toward the device
   output logic cmd_valid,
   output logic [31:0] cmd_word
);
   initial begin
      cmd_valid = 1'b0;
      cmd_word = 32'h0;
   end
   task send(input logic [31:0] w);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_word <= w;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      cmd_word <= ~w;
   endtask : send
endmodule : host_model

// [testbench.sv]
// Purpose: Self-checking bench for the generic flag status block.
// Assumes: The host model supplies command strobes.
// Notes: Event inputs are pulsed from the bench.
`timescale 1ns/1ns
module testbench;
   import flag_status_pkg::*;
   logic ref_clk, rst_n, cmd_valid, resp_valid, over_evt, sync_evt, en, rin_n;
   logic [31:0] cmd_word, resp_word;
   logic [3:0] flags;
   int err_count = 0;
   int comparisons = 0;
   localparam logic [31:0] rd_cmd = {rw_read, sel_generic_flags, 27'h0};
   generic_flag_status_read i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .cmd_valid(cmd_valid),
      .cmd_word(cmd_word), .overvoltage_event(over_evt), .phase_sync_event(sync_evt), .enable_in(en),
      .reset_in_n(rin_n), .resp_valid(resp_valid), .resp_word(resp_word), .flags(flags));
   host_model i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : give_verdict
   // Sends a read, then checks the response and the flags left behind.
   task rd(input logic [3:0] old, input logic [3:0] after);
      i_host.send(rd_cmd);
      #1;
      check({31'h0, resp_valid}, 32'h1);
      check(resp_word, {1'b0, sel_generic_flags, 23'h0, old});
      check({28'h0, flags}, {28'h0, after});
      @(posedge ref_clk);
      #1;
      check({31'h0, resp_valid}, 32'h0);
      check(resp_word, {1'b0, sel_generic_flags, 23'h0, old});
   endtask : rd
   task t_events;
      @(posedge ref_clk) {over_evt, sync_evt} <= 2'b11;
      @(posedge ref_clk) {over_evt, sync_evt} <= 2'b00;
      repeat (3) @(posedge ref_clk);
      #1 check({28'h0, flags}, 32'hc);
      rd(4'hc, 4'h0);
      $display("events done");
   endtask : t_events
   task t_refused;
      @(posedge ref_clk) over_evt <= 1'b1;
      @(posedge ref_clk) over_evt <= 1'b0;
      i_host.send({1'b1, sel_generic_flags, 27'h0});
      #1 check({31'h0, resp_valid}, 32'h0);
      i_host.send({rw_read, 4'he, 27'h0});
      #1 check({31'h0, resp_valid}, 32'h0);
      check({28'h0, flags}, 32'h8);
      rd(4'h8, 4'h0);
      $display("refused done");
   endtask : t_refused
   task t_enable;
      @(posedge ref_clk) en <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1 check({28'h0, flags}, 32'h2);
      rd(4'h2, 4'h2);
      @(posedge ref_clk) en <= 1'b1;
      rd(4'h2, 4'h0);
      $display("enable done");
   endtask : t_enable
   task t_reset_pin;
      @(posedge ref_clk) rin_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rin_n <= 1'b1;
      #1 check({28'h0, flags}, 32'h1);
      rd(4'h1, 4'h0);
      $display("reset pin done");
   endtask : t_reset_pin
   // Events land in the same cycle as a read; the sets must win over the clears.
   task t_collide;
      fork
         i_host.send(rd_cmd);
         begin
            @(posedge ref_clk) {over_evt, sync_evt, rin_n} <= 3'b110;
            @(posedge ref_clk) {over_evt, sync_evt, rin_n} <= 3'b001;
         end
      join
      #1;
      check({31'h0, resp_valid}, 32'h1);
      check(resp_word, {1'b0, sel_generic_flags, 23'h0, 4'h0});
      check({28'h0, flags}, 32'hd);
      rd(4'hd, 4'h0);
      $display("collide done");
   endtask : t_collide
   // Holds reset, releases it and checks every reset value before the first read.
   task t_reset;
      @(posedge ref_clk) rst_n <= 1'b0;
      repeat (11) @(posedge ref_clk);
      rst_n <= 1'b1;
      #1 check({28'h0, flags}, 32'h3);
      check({31'h0, resp_valid}, 32'h0);
      check(resp_word, 32'h0);
      rd(4'h3, 4'h0);
      $display("reset done");
   endtask : t_reset
   initial begin
      {rst_n, over_evt, sync_evt, en, rin_n} = 5'b00011;
      t_reset();
      t_events();
      t_refused();
      t_enable();
      t_reset_pin();
      t_collide();
      t_reset();
      give_verdict();
   end
   initial begin
      #2000;
      err_count++;
      give_verdict();
   end
endmodule : testbench
